// [common/seq_params.svh]
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: 200 MHz clock, 32-bit register port with byte addresses.
// Notes: Timing counts are derived from times in their own units.
`ifndef SEQ_PARAMS_SVH
`define SEQ_PARAMS_SVH

`define CLK_FREQ_MHZ 200
`define MGMT_INIT_TIME_US 2000
`define MGMT_INIT_CYCLES (`MGMT_INIT_TIME_US * `CLK_FREQ_MHZ)
`define TIMER_W 20

`define ADDR_W 8
`define DATA_W 32
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_FAULT_EN 8'h08
`define REG_FLAG 8'h0C

`define CTRL_SOFT_RESET_BIT 0
`define CTRL_SW_LOWPOWER_BIT 1
`define CTRL_HW_ALLOW_BIT 2
`define FLAG_STATE_CHANGE_BIT 0

`define SW_LOWPOWER_RESET 1'b0
`define HW_ALLOW_RESET 1'b1
`define SOFT_RESET_RESET 1'b0

`define FAULT_W 4
`define FAULT_EN_RESET 4'hF

`define LANE_COUNT 8
`define DP_STATE_W 4
`define PATH_DEACTIVATED_STATE 4'h1

`define STATE_CODE_W 4
`define CODE_SHUTDOWN 4'h0
`define CODE_RESET 4'h1
`define CODE_MGMT_INIT 4'h2
`define CODE_LOW_POWER 4'h3
`define CODE_POWER_UP 4'h4
`define CODE_READY 4'h5
`define CODE_POWER_DOWN 4'h6
`define CODE_FAULT 4'h7

`endif

// [common/seq_pkg.sv]
// Purpose: Types shared by the state sequencer modules.
// Assumes: Constants come from the params header.
// Notes: The main state is a single packed struct.
`include "seq_params.svh"

package seq_pkg;

   typedef enum logic [3:0] {
      ST_SHUTDOWN,
      ST_RESET,
      ST_MGMT_INIT,
      ST_LOW_POWER,
      ST_POWER_UP,
      ST_READY,
      ST_POWER_DOWN,
      ST_FAULT
   } seq_state_e;

   typedef logic [`DP_STATE_W-1:0] dp_state_t;

   typedef struct packed {
      seq_state_e st;
      logic soft_reset;
      logic sw_lowpower;
      logic hw_allow;
      logic flag;
      logic high_power;
      logic [`FAULT_W-1:0] fault_en;
      logic [`TIMER_W-1:0] timer;
      logic [`DATA_W-1:0] rdata;
   } seq_regs_s;

   typedef struct packed {
      logic s1;
      logic s2;
   } sync_bit_s;

endpackage : seq_pkg

// [common/cond_if.sv]
// Purpose: Carries the transition condition inputs and results.
// Assumes: All signals are on the module clock.
// Notes: The producer computes, the consumer steers the state machine.
`include "seq_params.svh"

interface cond_if;
   import seq_pkg::*;
   logic soft_reset;
   logic sw_lowpower;
   logic hw_allow;
   logic [`FAULT_W-1:0] fault_en;
   logic [`FAULT_W-1:0] fault_in;
   logic droop;
   logic hw_reset;
   logic hw_lowpower;
   dp_state_t [`LANE_COUNT-1:0] dp_state;
   logic reset_condition;
   logic fault_condition;
   logic low_power_condition;
   logic ready_exit_condition;
   logic all_paths_idle_term;

   modport producer (
      input soft_reset, sw_lowpower, hw_allow, fault_en, fault_in,
      input droop, hw_reset, hw_lowpower, dp_state,
      output reset_condition, fault_condition, low_power_condition,
      output ready_exit_condition, all_paths_idle_term
   );

   modport consumer (
      output soft_reset, sw_lowpower, hw_allow, fault_en, fault_in,
      output droop, hw_reset, hw_lowpower, dp_state,
      input reset_condition, fault_condition, low_power_condition,
      input ready_exit_condition, all_paths_idle_term
   );
endinterface : cond_if

// [hw/sync_2ff.sv]
// Purpose: Two flip-flop synchroniser for one asynchronous level.
// Assumes: Synchronous active-high reset.
// Notes: Only the second stage is visible outside.
module sync_2ff
   import seq_pkg::*;
#(
   parameter logic RESET_VALUE = 1'b0
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic async_in,
   output logic sync_out
);
   sync_bit_s q;
   sync_bit_s d;

   always_comb begin
      d.s1 = async_in;
      d.s2 = q.s1;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= '{s1: RESET_VALUE, s2: RESET_VALUE};
      end else begin
         q <= d;
      end
   end

   assign sync_out = q.s2;
endmodule : sync_2ff

// [hw/condition_logic.sv]
// Purpose: Computes the transition conditions of the state machine.
// Assumes: Pin levels arrive already synchronised.
// Notes: Purely combinational.
`include "seq_params.svh"

module condition_logic
   import seq_pkg::*;
(
   cond_if.producer cif
);
   // True when every lane reports the deactivated path state.
   function automatic logic paths_idle(
      input dp_state_t [`LANE_COUNT-1:0] s);
      logic idle;
      idle = 1'b1;
      for (int i = 0; i < `LANE_COUNT; i++) begin
         idle = idle & (s[i] == `PATH_DEACTIVATED_STATE);
      end
      return idle;
   endfunction : paths_idle

   always_comb begin
      cif.reset_condition = cif.droop | cif.hw_reset | cif.soft_reset;
      cif.fault_condition = |(cif.fault_in & cif.fault_en);
      cif.low_power_condition = cif.sw_lowpower
         | (cif.hw_allow & cif.hw_lowpower);
      cif.all_paths_idle_term = paths_idle(cif.dp_state);
      cif.ready_exit_condition = cif.low_power_condition
         & cif.all_paths_idle_term;
   end
endmodule : condition_logic

// [hw/module_state_sequencer.sv]
// Purpose: Module-wide reset, initialisation and power state sequencer.
// Assumes: Pins and droop detector are asynchronous; the rest is on clk.
// Notes: Registers are reached over a plain strobe port.
`include "seq_params.svh"

module module_state_sequencer
   import seq_pkg::*;
#(
   parameter logic [`TIMER_W-1:0] MGMT_INIT_CYCLES =
      `TIMER_W'(`MGMT_INIT_CYCLES)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic hw_reset_pin,
   input wire logic hw_lowpower_pin,
   input wire logic supply_droop_reset,
   input wire logic [`FAULT_W-1:0] fault_in,
   input wire dp_state_t [`LANE_COUNT-1:0] dp_state,
   input wire logic mgmt_ready,
   input wire logic powerup_done,
   input wire logic powerdown_done,
   input wire logic shutdown_done,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [`DATA_W-1:0] rdata,
   output logic mgmt_if_reset,
   output logic electronics_reset,
   output logic mgmt_access_en,
   output logic high_power_en,
   output logic state_change_flag,
   output logic [`STATE_CODE_W-1:0] state_code
);

   localparam seq_regs_s REGS_RESET = '{
      st: ST_RESET,
      soft_reset: `SOFT_RESET_RESET,
      sw_lowpower: `SW_LOWPOWER_RESET,
      hw_allow: `HW_ALLOW_RESET,
      flag: 1'b0,
      high_power: 1'b0,
      fault_en: `FAULT_EN_RESET,
      timer: '0,
      rdata: '0
   };

   seq_regs_s q;
   seq_regs_s d;
   cond_if cif ();

   logic hw_reset_s;
   logic hw_lowpower_s;
   logic droop_s;
   logic rc;
   logic fc;
   logic lpc;
   logic rex;
   logic entered;
   logic bus_open;

   sync_2ff #(
      .RESET_VALUE(1'b0)
   ) u_sync_reset (
      .clk(clk),
      .reset(reset),
      .async_in(hw_reset_pin),
      .sync_out(hw_reset_s)
   );

   sync_2ff #(
      .RESET_VALUE(1'b0)
   ) u_sync_lowpower (
      .clk(clk),
      .reset(reset),
      .async_in(hw_lowpower_pin),
      .sync_out(hw_lowpower_s)
   );

   sync_2ff #(
      .RESET_VALUE(1'b0)
   ) u_sync_droop (
      .clk(clk),
      .reset(reset),
      .async_in(supply_droop_reset),
      .sync_out(droop_s)
   );

   condition_logic u_cond (
      .cif(cif.producer)
   );

   assign cif.soft_reset = q.soft_reset;
   assign cif.sw_lowpower = q.sw_lowpower;
   assign cif.hw_allow = q.hw_allow;
   assign cif.fault_en = q.fault_en;
   assign cif.fault_in = fault_in;
   assign cif.droop = droop_s;
   assign cif.hw_reset = hw_reset_s;
   assign cif.hw_lowpower = hw_lowpower_s;
   assign cif.dp_state = dp_state;

   assign rc = cif.reset_condition;
   assign fc = cif.fault_condition;
   assign lpc = cif.low_power_condition;
   assign rex = cif.ready_exit_condition;

   // Maps a state to the code software reads back.
   function automatic logic [`STATE_CODE_W-1:0] code_of(
      input seq_state_e s);
      logic [`STATE_CODE_W-1:0] c;
      c = `CODE_RESET;
      case (s)
         ST_SHUTDOWN: c = `CODE_SHUTDOWN;
         ST_RESET: c = `CODE_RESET;
         ST_MGMT_INIT: c = `CODE_MGMT_INIT;
         ST_LOW_POWER: c = `CODE_LOW_POWER;
         ST_POWER_UP: c = `CODE_POWER_UP;
         ST_READY: c = `CODE_READY;
         ST_POWER_DOWN: c = `CODE_POWER_DOWN;
         ST_FAULT: c = `CODE_FAULT;
         default: c = `CODE_RESET;
      endcase
      return c;
   endfunction : code_of

   // True when the exit condition of a flagged state already holds.
   function automatic logic exit_holds(
      input seq_state_e s,
      input logic r,
      input logic f,
      input logic lp,
      input logic rx);
      logic h;
      h = 1'b0;
      case (s)
         ST_LOW_POWER: h = r | f | ~lp;
         ST_READY: h = r | f | rx;
         ST_FAULT: h = r;
         default: h = 1'b0;
      endcase
      return h;
   endfunction : exit_holds

   // True for the states whose entry raises the state change flag.
   function automatic logic flags_on_entry(input seq_state_e s);
      logic f;
      f = 1'b0;
      case (s)
         ST_LOW_POWER: f = 1'b1;
         ST_READY: f = 1'b1;
         ST_FAULT: f = 1'b1;
         default: f = 1'b0;
      endcase
      return f;
   endfunction : flags_on_entry

   // Writes are dropped while the management side is held or initialising.
   assign bus_open = (q.st != ST_RESET) && (q.st != ST_SHUTDOWN)
      && (q.st != ST_MGMT_INIT);

   always_comb begin
      d = q;
      entered = 1'b0;

      case (q.st)
         ST_RESET: begin
            d.high_power = 1'b0;
            d.soft_reset = 1'b0;
            if (!rc) begin
               d.st = ST_MGMT_INIT;
               d.timer = '0;
               d.sw_lowpower = `SW_LOWPOWER_RESET;
               d.hw_allow = `HW_ALLOW_RESET;
               d.fault_en = `FAULT_EN_RESET;
            end
         end
         ST_MGMT_INIT: begin
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end else if (fc) begin
               d.st = ST_FAULT;
            end else if (mgmt_ready
               || q.timer >= MGMT_INIT_CYCLES - `TIMER_W'(1)) begin
               d.st = ST_LOW_POWER;
            end else begin
               d.timer = q.timer + `TIMER_W'(1);
            end
         end
         ST_LOW_POWER: begin
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end else if (fc) begin
               d.st = ST_FAULT;
            end else if (!lpc) begin
               d.st = ST_POWER_UP;
               d.high_power = 1'b1;
            end
         end
         ST_POWER_UP: begin
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end else if (fc) begin
               d.st = ST_FAULT;
               d.high_power = 1'b0;
            end else if (lpc) begin
               d.st = ST_POWER_DOWN;
            end else if (powerup_done) begin
               d.st = ST_READY;
            end
         end
         ST_READY: begin
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end else if (fc) begin
               d.st = ST_FAULT;
               d.high_power = 1'b0;
            end else if (rex) begin
               d.st = ST_POWER_DOWN;
            end
         end
         ST_POWER_DOWN: begin
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end else if (fc) begin
               d.st = ST_FAULT;
               d.high_power = 1'b0;
            end else if (powerdown_done) begin
               d.st = ST_LOW_POWER;
               d.high_power = 1'b0;
            end
         end
         ST_FAULT: begin
            d.high_power = 1'b0;
            if (rc) begin
               d.st = ST_SHUTDOWN;
            end
         end
         ST_SHUTDOWN: begin
            if (shutdown_done) begin
               d.st = ST_RESET;
               d.high_power = 1'b0;
            end
         end
         default: begin
            d.st = ST_RESET;
         end
      endcase

      entered = (d.st != q.st) && flags_on_entry(d.st)
         && !exit_holds(d.st, rc, fc, lpc, rex);

      d.rdata = '0;
      if (rd) begin
         case (addr)
            `REG_CTRL: begin
               d.rdata[`CTRL_SOFT_RESET_BIT] = q.soft_reset;
               d.rdata[`CTRL_SW_LOWPOWER_BIT] = q.sw_lowpower;
               d.rdata[`CTRL_HW_ALLOW_BIT] = q.hw_allow;
            end
            `REG_STATUS: begin
               d.rdata[`STATE_CODE_W-1:0] = code_of(q.st);
            end
            `REG_FAULT_EN: begin
               d.rdata[`FAULT_W-1:0] = q.fault_en;
            end
            `REG_FLAG: begin
               d.rdata[`FLAG_STATE_CHANGE_BIT] = q.flag;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end

      if (wr && bus_open) begin
         case (addr)
            `REG_CTRL: begin
               d.soft_reset = wdata[`CTRL_SOFT_RESET_BIT];
               d.sw_lowpower = wdata[`CTRL_SW_LOWPOWER_BIT];
               d.hw_allow = wdata[`CTRL_HW_ALLOW_BIT];
            end
            `REG_FAULT_EN: begin
               d.fault_en = wdata[`FAULT_W-1:0];
            end
            `REG_FLAG: begin
               if (wdata[`FLAG_STATE_CHANGE_BIT]) begin
                  d.flag = 1'b0;
               end
            end
            default: begin
               d.flag = d.flag;
            end
         endcase
      end

      if (entered) begin
         d.flag = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         q <= REGS_RESET;
      end else begin
         q <= d;
      end
   end

   always_comb begin
      mgmt_if_reset = (q.st == ST_RESET) || (q.st == ST_SHUTDOWN);
      electronics_reset = (q.st == ST_RESET)
         || (q.st == ST_SHUTDOWN);
      mgmt_access_en = (q.st == ST_LOW_POWER) || (q.st == ST_POWER_UP)
         || (q.st == ST_READY) || (q.st == ST_POWER_DOWN)
         || (q.st == ST_FAULT);
      high_power_en = q.high_power;
   end

   assign rdata = q.rdata;
   assign state_change_flag = q.flag;
   assign state_code = code_of(q.st);
endmodule : module_state_sequencer

// [tb/host_ctl.sv]
// Purpose: Host side model driving the reset and low-power pins.
// Assumes: Requests from the bench are on the module clock.
// Notes: A reset request is stretched past the minimum pulse width.
module host_ctl #(
   parameter int MIN_PULSE_CYCLES = 8
) (
   input wire logic clk,
   input wire logic reset_req,
   input wire logic lp_req,
   output logic hw_reset_pin,
   output logic hw_lowpower_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int pulse_q;

   // The pin follows the request, so it can be high before startup.
   assign hw_lowpower_pin = lp_req;
   assign hw_reset_pin = reset_req || pulse_q != 0;

   always_ff @(posedge clk) begin
      if (reset_req) begin
         pulse_q <= MIN_PULSE_CYCLES + 1;
      end else if (pulse_q != 0) begin
         pulse_q <= pulse_q - 1;
      end
   end
endmodule : host_ctl

// [tb/seq_props.sv]
// Purpose: Concurrent checks on the state sequencer ports.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Bound to every instance of the sequencer.
`include "seq_params.svh"

module seq_props
   import seq_pkg::*;
#(
   parameter logic [`TIMER_W-1:0] MGMT_INIT_CYCLES =
      `TIMER_W'(`MGMT_INIT_CYCLES)
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [`FAULT_W-1:0] fault_in,
   input wire dp_state_t [`LANE_COUNT-1:0] dp_state,
   input wire logic shutdown_done,
   input wire logic mgmt_if_reset,
   input wire logic electronics_reset,
   input wire logic mgmt_access_en,
   input wire logic state_change_flag,
   input wire logic [`STATE_CODE_W-1:0] state_code
);
   logic [`TIMER_W-1:0] init_cnt_q;
   logic idle;
   logic flt;

   assign idle = dp_state == {`LANE_COUNT{`PATH_DEACTIVATED_STATE}};
   assign flt = fault_in != '0;

   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   always_ff @(posedge clk) begin
      if (reset || state_code != ST_MGMT_INIT) begin
         init_cnt_q <= '0;
      end else begin
         init_cnt_q <= init_cnt_q + 1'b1;
      end
   end

   property p_rst_exit;
      state_code == ST_RESET |=> state_code inside {ST_RESET, ST_MGMT_INIT};
   endproperty
   a_rst_exit: assert property (p_rst_exit)
      else $error("bad exit from reset state");

   property p_held;
      state_code inside {ST_SHUTDOWN, ST_RESET} |->
         mgmt_if_reset && electronics_reset && !mgmt_access_en;
   endproperty
   a_held: assert property (p_held)
      else $error("electronics not held in reset");

   property p_init_time;
      state_code == ST_MGMT_INIT |-> init_cnt_q <= MGMT_INIT_CYCLES;
   endproperty
   a_init_time: assert property (p_init_time)
      else $error("init state lasted too long");

   property p_fault_go;
      state_code inside {[ST_MGMT_INIT:ST_POWER_DOWN]} && flt |=>
         state_code inside {ST_FAULT, ST_SHUTDOWN};
   endproperty
   a_fault_go: assert property (p_fault_go)
      else $error("fault not taken");

   property p_fault_stay;
      state_code == ST_FAULT |=> state_code inside {ST_FAULT, ST_SHUTDOWN};
   endproperty
   a_fault_stay: assert property (p_fault_stay)
      else $error("fault state left without reset");

   property p_fault_flag;
      state_code == ST_FAULT && $past(state_code) != ST_FAULT |->
         state_change_flag;
   endproperty
   a_fault_flag: assert property (p_fault_flag)
      else $error("flag not raised on fault entry");

   property p_shut;
      state_code == ST_SHUTDOWN && shutdown_done |=> state_code == ST_RESET;
   endproperty
   a_shut: assert property (p_shut)
      else $error("shutdown did not reach reset");

   property p_ready;
      state_code == ST_READY && !idle && !flt |=>
         state_code inside {ST_READY, ST_SHUTDOWN};
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready left while lanes active");

   c_ready: cover property (state_code == ST_READY);
   c_fault: cover property (state_code == ST_FAULT);
   c_shut: cover property (state_code == ST_SHUTDOWN && shutdown_done);
endmodule : seq_props

bind module_state_sequencer seq_props #(
   .MGMT_INIT_CYCLES(MGMT_INIT_CYCLES)
) seq_props_inst (.clk, .reset, .fault_in, .dp_state, .shutdown_done,
   .mgmt_if_reset, .electronics_reset, .mgmt_access_en,
   .state_change_flag, .state_code);

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the module state sequencer.
// Assumes: Init time shortened to 20 cycles, 200 MHz clock.
// Notes: Registers are reached through rd_chk and wr_reg.
`include "seq_params.svh"

module tb_top
   import seq_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, reset = 1, reset_req = 0, lp_req = 1;
   logic supply_droop_reset = 0, mgmt_ready = 0, wr = 0, rd = 0;
   logic powerup_done = 0, powerdown_done = 0, shutdown_done = 0;
   logic [`FAULT_W-1:0] fault_in = '0;
   dp_state_t [`LANE_COUNT-1:0] dp_state = '0;
   logic [`ADDR_W-1:0] addr = '0;
   logic [`DATA_W-1:0] wdata = '0, rdata;
   logic hw_reset_pin, hw_lowpower_pin, mgmt_if_reset, electronics_reset;
   logic mgmt_access_en, high_power_en, state_change_flag;
   logic [`STATE_CODE_W-1:0] state_code;
   int err_total = 0, n_checks = 0;

   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end

   host_ctl host_ctl_inst (.clk, .reset_req, .lp_req, .hw_reset_pin,
      .hw_lowpower_pin);

   module_state_sequencer #(
      .MGMT_INIT_CYCLES(`TIMER_W'(20))
   ) module_state_sequencer_inst (.clk, .reset, .hw_reset_pin,
      .hw_lowpower_pin, .supply_droop_reset, .fault_in, .dp_state,
      .mgmt_ready, .powerup_done, .powerdown_done, .shutdown_done, .addr,
      .wdata, .wr, .rd, .rdata, .mgmt_if_reset, .electronics_reset,
      .mgmt_access_en, .high_power_en, .state_change_flag, .state_code);

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   task end_of_test;
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test

   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, exp);
   endtask : rd_chk

   task wait_st(input logic [3:0] c, input int n);
      int i;
      for (i = 0; i < n; i++) begin
         @(negedge clk);
         if (state_code === c) begin
            break;
         end
      end
      chk(state_code, c);
      if (state_code !== c) begin
         end_of_test();
      end
   endtask : wait_st

   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      wait_st(ST_MGMT_INIT, 4);
      wait_st(ST_LOW_POWER, 24);
      chk(state_change_flag, 1'b1);
      chk({mgmt_access_en, mgmt_if_reset, electronics_reset}, 3'h4);
      rd_chk(`REG_CTRL, 32'h4);
      rd_chk(`REG_STATUS, 32'h3);
      rd_chk(`REG_FAULT_EN, 32'hF);
      rd_chk(8'hF0, 32'h0);
      wr_reg(`REG_FAULT_EN, 32'h5);
      rd_chk(`REG_FAULT_EN, 32'h5);
      wr_reg(`REG_FLAG, 32'h1);
      rd_chk(`REG_FLAG, 32'h0);
      @(posedge clk);
      lp_req <= 1'b0;
      wait_st(ST_POWER_UP, 6);
      @(posedge clk);
      powerup_done <= 1'b1;
      wait_st(ST_READY, 3);
      chk({state_change_flag, high_power_en}, 2'h3);
      @(posedge clk);
      lp_req <= 1'b1;
      dp_state <= {4'h0, {7{`PATH_DEACTIVATED_STATE}}};
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(state_code, ST_READY);
      @(posedge clk);
      dp_state[7] <= `PATH_DEACTIVATED_STATE;
      wait_st(ST_POWER_DOWN, 3);
      @(posedge clk);
      powerdown_done <= 1'b1;
      powerup_done <= 1'b0;
      wait_st(ST_LOW_POWER, 3);
      wr_reg(`REG_CTRL, 32'h0);
      wait_st(ST_POWER_UP, 3);
      wr_reg(`REG_CTRL, 32'h2);
      wait_st(ST_POWER_DOWN, 3);
      wait_st(ST_LOW_POWER, 3);
      chk(high_power_en, 1'b0);
      wr_reg(`REG_FLAG, 32'h1);
      fault_in <= 4'h1;
      wait_st(ST_FAULT, 3);
      chk({state_change_flag, high_power_en}, 2'h2);
      @(posedge clk);
      fault_in <= '0;
      wr_reg(`REG_CTRL, 32'h0);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk(state_code, ST_FAULT);
      @(posedge clk);
      shutdown_done <= 1'b1;
      mgmt_ready <= 1'b1;
      wr_reg(`REG_CTRL, 32'h1);
      wait_st(ST_SHUTDOWN, 3);
      chk({mgmt_access_en, mgmt_if_reset, electronics_reset}, 3'h3);
      wait_st(ST_RESET, 3);
      wait_st(ST_LOW_POWER, 6);
      rd_chk(`REG_CTRL, 32'h4);
      @(posedge clk);
      supply_droop_reset <= 1'b1;
      wait_st(ST_RESET, 8);
      repeat (5) @(posedge clk);
      @(negedge clk);
      chk(state_code, ST_RESET);
      @(posedge clk);
      supply_droop_reset <= 1'b0;
      wait_st(ST_LOW_POWER, 10);
      @(posedge clk);
      reset_req <= 1'b1;
      @(posedge clk);
      reset_req <= 1'b0;
      wait_st(ST_RESET, 8);
      wait_st(ST_LOW_POWER, 20);
      wr_reg(`REG_CTRL, 32'h5);
      fault_in <= 4'h1;
      wait_st(ST_SHUTDOWN, 2);
      wait_st(ST_MGMT_INIT, 4);
      wait_st(ST_FAULT, 2);
      end_of_test();
   end
endmodule : tb_top
